// >>> verilog/uirq_pkg.sv
// Package for the UART interrupt, divider and input-pin register slice
`default_nettype none
package uirq_pkg;

    // ****************************************
    // Register byte addresses (APB, one word each)
    // ****************************************
    localparam logic [7:0] UIRQ_ADDR_AUX_CONTROL  = 8'h00;
    localparam logic [7:0] UIRQ_ADDR_IRQ_STAT_MSK = 8'h04;
    localparam logic [7:0] UIRQ_ADDR_DIVIDER_HIGH = 8'h08;
    localparam logic [7:0] UIRQ_ADDR_DIVIDER_LOW  = 8'h0c;
    localparam logic [7:0] UIRQ_ADDR_INPUT_PIN    = 8'h10;
    localparam logic [7:0] UIRQ_ADDR_INPUT_CHANGE = 8'h14;
    localparam logic [7:0] UIRQ_ADDR_MODE_ONE     = 8'h18;
    localparam logic [7:0] UIRQ_ADDR_COMMAND      = 8'h1c;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int UIRQ_AUX_IEC_BIT    = 0;
    localparam int UIRQ_ST_CHANGE_BIT  = 7;
    localparam int UIRQ_ST_BREAK_BIT   = 2;
    localparam int UIRQ_ST_RXLVL_BIT   = 1;
    localparam int UIRQ_ST_TX_HOLDING_EMPTY_BIT   = 0;
    localparam int UIRQ_ICR_COS_BIT    = 4;
    localparam int UIRQ_PIN_CTS_BIT    = 0;
    localparam int UIRQ_MR1_RXSEL_BIT  = 6;
    localparam int UIRQ_CMD_RSTBRK_BIT = 0;

    // Implemented bit masks; reserved bits read zero and ignore writes
    localparam logic [7:0] UIRQ_MASK_BITS = 8'h87;

    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [7:0]  UIRQ_RST_BYTE     = 8'h00;
    localparam logic [15:0] UIRQ_DIV_MIN      = 16'h0002;
    localparam int          UIRQ_CLK_HZ       = 10_000_000;
    localparam int          UIRQ_FILTER_US    = 25;
    localparam int          UIRQ_FILTER_CYC   = (UIRQ_FILTER_US * (UIRQ_CLK_HZ / 1_000_000));
    localparam int          UIRQ_PRESCALE     = 32;

    typedef struct packed {
        logic       rx_ready;
        logic       fifo_full;
        logic       tx_holding_empty;
        logic       break_edge;
    } uirq_chan_type;

endpackage : uirq_pkg
`default_nettype wire

// >>> verilog/uirq_cts_filter.sv
// Glitch filter that qualifies clear-to-send transitions
`default_nettype none
module uirq_cts_filter
    import uirq_pkg::*;
#(
    parameter int FILTER_CYC = UIRQ_FILTER_CYC
) (
    input  wire logic mclk,         // Bus clock
    input  wire logic rst_n,        // Synchronous reset, active low
    input  wire logic ce,           // Clock enable
    input  wire logic pin,          // Raw clear-to-send level
    output logic      level,        // Filtered level
    output logic      changed       // One-cycle pulse on a qualified change
);

    initial begin
        if (FILTER_CYC < 1 || FILTER_CYC > 65535) begin
            $error("FILTER_CYC out of range");
        end
    end

    typedef struct packed {
        logic        level;
        logic        changed;
        logic [15:0] cnt;
    } uirq_flt_type;

    uirq_flt_type s_r;
    uirq_flt_type s_nxt;

    always_comb begin
        s_nxt         = s_r;
        s_nxt.changed = 1'b0;
        if (pin == s_r.level) begin
            s_nxt.cnt = '0;
        // Only a level held past the filter interval counts as a change
        end else if (s_r.cnt == 16'(FILTER_CYC - 1)) begin
            s_nxt.level   = pin;
            s_nxt.changed = 1'b1;
            s_nxt.cnt     = '0;
        end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign level   = s_r.level;
    assign changed = s_r.changed;

endmodule : uirq_cts_filter
`default_nettype wire

// >>> verilog/uirq_regs.sv
// UART interrupt status/mask, divider and input-pin register slice
`default_nettype none
module uirq_regs
    import uirq_pkg::*;
#(
    parameter int FILTER_CYC = UIRQ_FILTER_CYC,
    parameter int PRESCALE   = UIRQ_PRESCALE
) (
    input  wire logic          mclk,            // Bus clock, 10 MHz
    input  wire logic          rst_n,           // Synchronous reset, active low
    input  wire logic          ce,              // Clock enable, freezes state
    input  wire logic          psel,            // APB select
    input  wire logic          penable,         // APB access phase
    input  wire logic          pwrite,          // APB write
    input  wire logic [7:0]    paddr,           // APB byte address
    input  wire logic [31:0]   pwdata,          // APB write data
    output logic               pready,          // APB ready
    output logic [31:0]        prdata,          // APB read data
    output logic               pslverr,         // APB error on unmapped address
    input  wire logic          cts_pin,         // Clear-to-send input level
    input  wire uirq_chan_type chan,            // Channel status and break edge
    output logic               irq,             // Internal interrupt output
    output logic [15:0]        divider,         // Baud divider to the bit clock
    output logic               bit_clk_tick     // Divided bit-clock tick
);

    // ****************************************
    // Parameter checks
    // ****************************************
    initial begin
        if (PRESCALE < 1 || PRESCALE > 255) begin
            $error("PRESCALE out of range");
        end
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0]  aux;
        logic [7:0]  mask;
        logic [7:0]  status;
        logic        mode_rxsel;
        logic        icr_cos;
        logic [7:0]  div_hi;
        logic [7:0]  div_lo;
        logic [7:0]  pre_cnt;
        logic [15:0] div_cnt;
        logic        tick;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } uirq_state_type;

    uirq_state_type s_r;
    uirq_state_type s_nxt;

    logic cts_level;
    logic cts_changed;

    uirq_cts_filter #(
        .FILTER_CYC (FILTER_CYC)
    ) u_filter (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .ce      (ce),
        .pin     (cts_pin),
        .level   (cts_level),
        .changed (cts_changed)
    );

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == UIRQ_ADDR_AUX_CONTROL)  || (a == UIRQ_ADDR_IRQ_STAT_MSK) ||
               (a == UIRQ_ADDR_DIVIDER_HIGH) || (a == UIRQ_ADDR_DIVIDER_LOW)  ||
               (a == UIRQ_ADDR_INPUT_PIN)    || (a == UIRQ_ADDR_INPUT_CHANGE) ||
               (a == UIRQ_ADDR_MODE_ONE)     || (a == UIRQ_ADDR_COMMAND);
    endfunction : addr_mapped

    logic setup;
    logic wr;
    logic rd;
    logic icr_read;
    logic brk_clear;

    assign setup     = psel && !penable;
    assign wr        = setup && pwrite;
    assign rd        = setup && !pwrite;
    assign icr_read  = rd && (paddr == UIRQ_ADDR_INPUT_CHANGE);
    assign brk_clear = wr && (paddr == UIRQ_ADDR_COMMAND) && pwdata[UIRQ_CMD_RSTBRK_BIT];

    always_comb begin
        s_nxt         = s_r;
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        s_nxt.tick    = 1'b0;

        // ****************************************
        // Register writes (taken in setup, answered next cycle)
        // ****************************************
        if (wr) begin
            if (paddr == UIRQ_ADDR_AUX_CONTROL) begin
                s_nxt.aux = pwdata[7:0] & 8'h01;
            // Writes at shared address reach the mask only
            end else if (paddr == UIRQ_ADDR_IRQ_STAT_MSK) begin
                s_nxt.mask = pwdata[7:0] & UIRQ_MASK_BITS;
            end else if (paddr == UIRQ_ADDR_DIVIDER_HIGH) begin
                s_nxt.div_hi = pwdata[7:0];
            end else if (paddr == UIRQ_ADDR_DIVIDER_LOW) begin
                s_nxt.div_lo = pwdata[7:0];
            end else if (paddr == UIRQ_ADDR_MODE_ONE) begin
                s_nxt.mode_rxsel = pwdata[UIRQ_MR1_RXSEL_BIT];
            end
        end

        // ****************************************
        // Read data
        // ****************************************
        if (rd) begin
            s_nxt.prdata = '0;
            if (paddr == UIRQ_ADDR_AUX_CONTROL) begin
                s_nxt.prdata[7:0] = s_r.aux;
            // Reads at shared address return status
            end else if (paddr == UIRQ_ADDR_IRQ_STAT_MSK) begin
                s_nxt.prdata[7:0] = s_r.status;
            // Pin level sampled at the read
            end else if (paddr == UIRQ_ADDR_INPUT_PIN) begin
                s_nxt.prdata[UIRQ_PIN_CTS_BIT] = cts_pin;
            end else if (paddr == UIRQ_ADDR_INPUT_CHANGE) begin
                s_nxt.prdata[UIRQ_ICR_COS_BIT] = s_r.icr_cos;
                s_nxt.prdata[UIRQ_PIN_CTS_BIT] = cts_level;
            end else if (paddr == UIRQ_ADDR_MODE_ONE) begin
                s_nxt.prdata[UIRQ_MR1_RXSEL_BIT] = s_r.mode_rxsel;
            end
            // Divider addresses fall through and read zero
        end
        if (setup) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = !addr_mapped(paddr);
        end

        // ****************************************
        // Interrupt status
        // ****************************************
        // Change register cleared by its read; a new change wins
        if (icr_read) begin
            s_nxt.icr_cos = 1'b0;
            s_nxt.status[UIRQ_ST_CHANGE_BIT] = 1'b0;
        end
        if (cts_changed) begin
            s_nxt.icr_cos = 1'b1;
            // Status follows the change only when enabled
            if (s_r.aux[UIRQ_AUX_IEC_BIT]) begin
                s_nxt.status[UIRQ_ST_CHANGE_BIT] = 1'b1;
            end
        end
        if (!s_nxt.aux[UIRQ_AUX_IEC_BIT]) begin
            s_nxt.status[UIRQ_ST_CHANGE_BIT] = 1'b0;
        end
        // Break change sticky until command; set wins over clear
        if (brk_clear) begin
            s_nxt.status[UIRQ_ST_BREAK_BIT] = 1'b0;
        end
        if (chan.break_edge) begin
            s_nxt.status[UIRQ_ST_BREAK_BIT] = 1'b1;
        end
        // Receiver or FIFO level, selected by mode bit
        s_nxt.status[UIRQ_ST_RXLVL_BIT] = s_r.mode_rxsel ? chan.fifo_full : chan.rx_ready;
        s_nxt.status[UIRQ_ST_TX_HOLDING_EMPTY_BIT] = chan.tx_holding_empty;

        // Recomputed each cycle, no extra latching
        s_nxt.irq = |(s_nxt.status & s_nxt.mask);

        // ****************************************
        // Bit clock: prescale then divide
        // ****************************************
        // Divider below the minimum stalls the tick rather than running wild
        if (s_r.pre_cnt == 8'(PRESCALE - 1)) begin
            s_nxt.pre_cnt = '0;
            // Concatenated divider sets the bit rate
            if ({s_r.div_hi, s_r.div_lo} >= UIRQ_DIV_MIN) begin
                if (s_r.div_cnt >= {s_r.div_hi, s_r.div_lo} - 16'h0001) begin
                    s_nxt.div_cnt = '0;
                    s_nxt.tick    = 1'b1;
                end else begin
                    s_nxt.div_cnt = s_r.div_cnt + 16'h0001;
                end
            end else begin
                s_nxt.div_cnt = '0;
            end
        end else begin
            s_nxt.pre_cnt = s_r.pre_cnt + 8'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r        <= '0;
            s_r.div_lo <= UIRQ_RST_BYTE;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign pready       = s_r.pready;
    assign pslverr      = s_r.pslverr;
    assign prdata       = s_r.prdata;
    assign irq          = s_r.irq;
    assign divider      = {s_r.div_hi, s_r.div_lo};
    assign bit_clk_tick = s_r.tick;

endmodule : uirq_regs
`default_nettype wire

// >>> bench/uirq_regs_properties.sv
// Concurrent checks on the register slice ports
`default_nettype none
module uirq_regs_properties
    import uirq_pkg::*;
#(
    parameter int FILTER_CYC = 4,
    parameter int PRESCALE   = 2
) (
    input wire logic        mclk,    // Bus clock
    input wire logic        rst_n,   // Reset, active low
    input wire logic        ce,      // Clock enable
    input wire logic        psel,    // Select
    input wire logic        penable, // Access phase
    input wire logic        pwrite,  // Write
    input wire logic [7:0]  paddr,   // Byte address
    input wire logic [31:0] pwdata,  // Write data
    input wire logic        pready,  // Ready
    input wire logic [31:0] prdata,  // Read data
    input wire logic        pslverr, // Error
    input wire logic        cts_pin, // Pin level
    input wire logic        irq,     // Interrupt
    input wire logic [15:0] divider  // Baud divider
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire rd_t = psel && !penable && !pwrite && ce;
    wire wr_t = psel && !penable && pwrite && ce;
    a_ready_next: assert property (
        psel && !penable && ce |=> pready) else $error("no ready after setup");
    a_unmapped_err: assert property (
        (rd_t || wr_t) && paddr > 8'h1c |=> pslverr && (!$past(rd_t) || prdata == 32'h0))
        else $error("unmapped");
    a_div_hidden: assert property (
        rd_t && (paddr == UIRQ_ADDR_DIVIDER_HIGH || paddr == UIRQ_ADDR_DIVIDER_LOW)
        |=> prdata == 32'h0) else $error("divider readable");
    a_pin_latch: assert property (
        rd_t && paddr == UIRQ_ADDR_INPUT_PIN |=> prdata == {31'h0, $past(cts_pin)})
        else $error("pin read wrong");
    a_aux_reserved: assert property (
        rd_t && paddr == UIRQ_ADDR_AUX_CONTROL |=> prdata[31:1] == 31'h0) else $error("aux rsvd");
    a_stat_reserved: assert property (
        rd_t && paddr == UIRQ_ADDR_IRQ_STAT_MSK |=> prdata[31:8] == 24'h0 && prdata[6:3] == 4'h0)
        else $error("status rsvd");
    a_div_low_load: assert property (
        wr_t && paddr == UIRQ_ADDR_DIVIDER_LOW |=> divider[7:0] == $past(pwdata[7:0]))
        else $error("low byte");
    a_div_high_load: assert property (
        wr_t && paddr == UIRQ_ADDR_DIVIDER_HIGH |=> divider[15:8] == $past(pwdata[7:0]))
        else $error("high byte");
    a_reset_clear: assert property (
        $rose(rst_n) |-> !irq && divider == 16'h0) else $error("reset state");
    a_irq_mask_off: assert property (
        wr_t && paddr == UIRQ_ADDR_IRQ_STAT_MSK && pwdata[7:0] == 8'h00 |=> ##1 !irq)
        else $error("irq with mask clear");
endmodule : uirq_regs_properties

bind uirq_regs uirq_regs_properties #(.FILTER_CYC(FILTER_CYC), .PRESCALE(PRESCALE)) u_props (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cts_pin(cts_pin), .irq(irq), .divider(divider));
`default_nettype wire

// >>> bench/uirq_cts_partner.sv
// Remote device model driving the clear-to-send level
`default_nettype none
module uirq_cts_partner (
    input  wire logic mclk,    // Bus clock
    output var logic  cts_pin  // Clear-to-send level
);
    timeunit 1ns;
    timeprecision 1ns;
    initial cts_pin = 1'b0;
    // ****
    // Line activity
    // ****
    // level held past filter
    task automatic hold(input logic v, input int n);
        @(posedge mclk);
        cts_pin <= v;
        repeat (n) @(posedge mclk);
    endtask : hold
    // brief pulse that must not count
    task automatic glitch(input int n);
        logic v0;
        v0 = cts_pin;
        @(posedge mclk);
        cts_pin <= !v0;
        repeat (n) @(posedge mclk);
        cts_pin <= v0;
    endtask : glitch
endmodule : uirq_cts_partner
`default_nettype wire

// >>> bench/test_uart_irq_baud_input_regs.sv
// Self-checking bench for the interrupt, divider and input-pin registers
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] %0t: got %h exp %h", $time, got, exp); end end
module test_uart_irq_baud_input_regs;
    import uirq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FCYC = 4;
    localparam int PSC  = 2;
    logic          mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic          irq, tick, cts_pin, err;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0, prdata, r, rr;
    logic [15:0]   divider, d;
    uirq_chan_type chan = '0;
    int            mismatches = 0, compares = 0, n, m_st7 = 0, m_st2 = 0, m_mask = 0, m_sel = 0;
    always #50 mclk = ~mclk;
    uirq_regs #(.FILTER_CYC(FCYC), .PRESCALE(PSC)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .cts_pin(cts_pin), .chan(chan), .irq(irq), .divider(divider), .bit_clk_tick(tick));
    uirq_cts_partner u_cts (.mclk(mclk), .cts_pin(cts_pin));
    // ****
    // Tasks
    // ****
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        int k;
        k = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= dat;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            wrap_up();
        end
        r   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(r, e)
    endtask : rchk
    // Status as the rules define it, independent of the mask
    function automatic logic [7:0] exp_st();
        return {m_st7[0], 4'h0, m_st2[0], m_sel[0] ? chan.fifo_full : chan.rx_ready,
                chan.tx_holding_empty};
    endfunction : exp_st
    // ****
    // Main sequence
    // ****
    initial begin
        r = $urandom(74543);
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rchk(UIRQ_ADDR_IRQ_STAT_MSK, 32'h0);
        apb(1'b1, UIRQ_ADDR_IRQ_STAT_MSK, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        `CHK(err, 1'b1)
        // divider kept at two or more, low byte always written
        for (int i = 0; i < 3; i++) begin
            d = (i == 2) ? 16'h0002 : 16'($urandom_range(2, 16'hffff));
            apb(1'b1, UIRQ_ADDR_DIVIDER_HIGH, {24'h0, d[15:8]});
            apb(1'b1, UIRQ_ADDR_DIVIDER_LOW, {24'h0, d[7:0]});
            `CHK(divider, d)
            rchk(UIRQ_ADDR_DIVIDER_HIGH, 32'h0);
            rchk(UIRQ_ADDR_DIVIDER_LOW, 32'h0);
        end
        n = 0;
        repeat (8) @(posedge mclk);
        for (int i = 0; i < 4 * PSC * 2; i++) begin
            @(posedge mclk);
            n += int'(tick === 1'b1);
        end
        `CHK(n, 4)
        for (int i = 0; i < 12; i++) begin
            m_sel = $urandom_range(0, 1);
            rr = $urandom;
            m_mask = rr[7:0] & 8'h87;
            @(posedge mclk);
            chan <= uirq_chan_type'({3'($urandom_range(0, 7)), 1'(i % 3 == 0)});
            m_st2 = (i % 3 == 0) ? 1 : m_st2;
            @(posedge mclk);
            chan.break_edge <= 1'b0;
            apb(1'b1, UIRQ_ADDR_MODE_ONE, {25'h0, m_sel[0], 6'h0});
            apb(1'b1, UIRQ_ADDR_IRQ_STAT_MSK, rr);
            rchk(UIRQ_ADDR_IRQ_STAT_MSK, {24'h0, exp_st()});
            `CHK(irq, |(exp_st() & m_mask[7:0]))
            if (i % 4 == 3) begin
                apb(1'b1, UIRQ_ADDR_COMMAND, 32'h1);
                m_st2 = 0;
            end
        end
        apb(1'b1, UIRQ_ADDR_AUX_CONTROL, 32'h0);
        u_cts.hold(1'b1, FCYC + 8);
        rchk(UIRQ_ADDR_IRQ_STAT_MSK, {24'h0, exp_st()});
        rchk(UIRQ_ADDR_INPUT_CHANGE, 32'h11);
        apb(1'b1, UIRQ_ADDR_AUX_CONTROL, 32'hff);
        rchk(UIRQ_ADDR_AUX_CONTROL, 32'h1);
        u_cts.glitch(FCYC - 2);
        repeat (FCYC + 4) @(posedge mclk);
        rchk(UIRQ_ADDR_IRQ_STAT_MSK, {24'h0, exp_st()});
        u_cts.hold(1'b0, FCYC + 8);
        m_st7 = 1;
        rchk(UIRQ_ADDR_IRQ_STAT_MSK, {24'h0, exp_st()});
        apb(1'b1, UIRQ_ADDR_IRQ_STAT_MSK, 32'h80);
        `CHK(irq, 1'b1)
        rchk(UIRQ_ADDR_INPUT_CHANGE, 32'h10);
        m_st7 = 0;
        rchk(UIRQ_ADDR_IRQ_STAT_MSK, {24'h0, exp_st()});
        `CHK(irq, 1'b0)
        for (int i = 0; i < 4; i++) begin
            u_cts.hold(1'($urandom_range(0, 1)), 2);
            rchk(UIRQ_ADDR_INPUT_PIN, {31'h0, cts_pin});
        end
        @(posedge mclk);
        chan  <= '0;
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rchk(UIRQ_ADDR_IRQ_STAT_MSK, 32'h0);
        `CHK(divider, 16'h0)
        wrap_up();
    end
endmodule : test_uart_irq_baud_input_regs
`default_nettype wire
